// file: design/pfm_pkg.sv
// pin function mux constants, register map and pad carrier type
package pfm_pkg;
    typedef struct packed {
        logic out;
        logic oe_n;
    } pfm_pad_t;

    localparam int unsigned PFM_KROWS   = 15;
    localparam int unsigned PFM_GCS     = 15;
    localparam int unsigned PFM_CTLPINS = 8;
    localparam int unsigned PFM_MAPINS  = 12;
    localparam int unsigned PFM_PBPINS  = 3;
    localparam int unsigned PFM_SCAN    = 4;

    localparam logic [7:0] PFM_OFS_CTRL   = 8'h00;
    localparam logic [7:0] PFM_OFS_STATUS = 8'h04;

    localparam int unsigned PFM_C_GFX    = 0;
    localparam int unsigned PFM_C_DRAM32 = 1;
    localparam int unsigned PFM_C_VLBUS  = 2;
    localparam int unsigned PFM_C_IR     = 3;
    localparam int unsigned PFM_C_PAR    = 4;
    localparam int unsigned PFM_C_BANKS  = 5;
    localparam int unsigned PFM_C_TOP_MEMORY_ADDRESS_BIT   = 6;
    localparam int unsigned PFM_C_ISA    = 7;
    localparam int unsigned PFM_C_ROM3   = 8;
    localparam int unsigned PFM_C_TGT_LO = 9;
    localparam int unsigned PFM_C_TGT_HI = 12;
    localparam int unsigned PFM_C_BITS   = 13;
    localparam logic [12:0] PFM_CTRL_RST = 13'h0000;

    localparam logic [1:0] PFM_W8  = 2'h0;
    localparam logic [1:0] PFM_W16 = 2'h1;
    localparam logic [1:0] PFM_W32 = 2'h2;

    // keyboard rows carrying memory strobes, address bit, buffer enable
    localparam logic [14:0] PFM_ROW_BANKS = 15'h003F & ~15'h0040;
    localparam int unsigned PFM_ROW_TOP_MEMORY_ADDRESS_BIT  = 6;
    localparam int unsigned PFM_ROW_R32   = 13;
    localparam logic [14:0] PFM_ROW_ISA   = 15'h1F80;
    localparam logic [14:0] PFM_GCS_DBUF  = 15'h001C;

    localparam logic [1:0] PFM_RESP_OK  = 2'h0;
    localparam logic [1:0] PFM_RESP_ERR = 2'h2;
endpackage : pfm_pkg

// file: design/pfm_pin_mux.sv
// shared pin function selection with axi4-lite configuration
// Notes on behaviour
// - local bus pins act only while the graphics controller is disabled.
// - wide dram, wide rom or local bus makes graphics controller unavailable.
// - bank 2/3 and high word strobes use keyboard rows when memory selected.
// - top memory address bit goes out on a keyboard row pin.
// - extra bus controls sit on keyboard row pins when enabled.
// - high word data buffer controls are driven on gpio chip-select pins.
// - wide rom buffer enable drives a keyboard row for 32-bit rom.
// - parallel port and second card socket never share pins at once.
// - one uart, serial or infrared selectable at run time, one at a time.
// - third rom select has no pin; software enables and steers it.
// - slash pins carry either function at different times in one design.
// - reset-function pins present that function during hardware reset.
// - firmware alternate functions come from software settings, one each.
// - strap alternate functions come from pin levels sampled at power-on.
// - four scan functions enabled by the scan select input only.
// - boot rom width 8/16/32 comes from two straps at power-up.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module pfm_pin_mux (
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_srst,
    input  wire logic                                 i_hw_reset,
    input  wire logic                                 i_scan_pin_select,
    input  wire logic                                 i_dbuf_strap,
    // axi4-lite slave
    input  wire logic [7:0]                           i_awaddr,
    input  wire logic                                 i_awvalid,
    output logic                                      o_awready,
    input  wire logic [31:0]                          i_wdata,
    input  wire logic [3:0]                           i_wstrb,
    input  wire logic                                 i_wvalid,
    output logic                                      o_wready,
    output logic [1:0]                                o_bresp,
    output logic                                      o_bvalid,
    input  wire logic                                 i_bready,
    input  wire logic [7:0]                           i_araddr,
    input  wire logic                                 i_arvalid,
    output logic                                      o_arready,
    output logic [31:0]                               o_rdata,
    output logic [1:0]                                o_rresp,
    output logic                                      o_rvalid,
    input  wire logic                                 i_rready,
    // function side drives
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_CTLPINS-1:0] i_gfx_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_CTLPINS-1:0] i_vl_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_KROWS-1:0]   i_kbd_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_KROWS-1:0]   i_kalt_drv,
    input  wire logic [12:0]                          i_mem_ma,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_GCS-1:0]     i_gpio_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_GCS-1:0]     i_dbuf_drv,
    input  wire logic                                 i_third_rom_select,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_PBPINS-1:0]  i_par_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_PBPINS-1:0]  i_sockb_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_SCAN-1:0]    i_card_drv,
    input  pfm_pkg::pfm_pad_t [pfm_pkg::PFM_SCAN-1:0]    i_scan_drv,
    input  wire logic                                 i_uart_txd,
    input  wire logic                                 i_ser_rxd,
    input  wire logic                                 i_ir_rxd,
    input  wire logic [1:0]                           i_ma_pad_in,
    // pads
    output pfm_pkg::pfm_pad_t [pfm_pkg::PFM_CTLPINS-1:0] o_ctl_pad,
    output pfm_pkg::pfm_pad_t [pfm_pkg::PFM_KROWS-1:0]   o_kbd_pad,
    output pfm_pkg::pfm_pad_t [pfm_pkg::PFM_MAPINS-1:0]  o_ma_pad,
    output pfm_pkg::pfm_pad_t [pfm_pkg::PFM_GCS-1:0]     o_gcs_pad,
    output pfm_pkg::pfm_pad_t [pfm_pkg::PFM_PBPINS-1:0]  o_pb_pad,
    output pfm_pkg::pfm_pad_t [pfm_pkg::PFM_SCAN-1:0]    o_scan_pad,
    output logic                                      o_ser_txd,
    output logic                                      o_ir_txd,
    output logic                                      o_uart_rxd,
    output logic                                      o_gfx_active,
    output logic                                      o_vl_active,
    output logic [1:0]                                o_boot_width
);
    import pfm_pkg::*;

    localparam pfm_pad_t PAD_OFF = '{out: 1'b0, oe_n: 1'b1};

    function automatic pfm_pad_t pad_pick(input logic sel, input pfm_pad_t alt, input pfm_pad_t pri);
        pad_pick = sel ? alt : pri;
    endfunction : pad_pick

    logic [PFM_C_BITS-1:0] ctrl;
    logic [1:0]            boot_width;
    logic                  dbuf_en;
    logic                  aw_held;
    logic                  w_held;
    logic [7:0]            aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  any_reset;
    logic                  rom32;
    logic                  gfx_avail;
    logic                  gfx_act;
    logic                  vl_act;
    logic [14:0]           row_alt;
    logic [3:0]            rom3_tgt;
    logic [31:0]           status_word;

    assign any_reset = i_srst | i_hw_reset;
    assign rom32     = (boot_width == PFM_W32);
    assign rom3_tgt  = ctrl[PFM_C_TGT_HI:PFM_C_TGT_LO];

    // power-on strap capture, held until next power-on
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            boot_width <= i_ma_pad_in[1] ? PFM_W32 : (i_ma_pad_in[0] ? PFM_W16 : PFM_W8);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            dbuf_en <= i_dbuf_strap;
        end
    end

    // axi4-lite write path
    assign o_awready = ~aw_held & ~o_bvalid;
    assign o_wready  = ~w_held & ~o_bvalid;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (aw_held & w_held) begin
            aw_held <= 1'b0;
        end else if (i_awvalid & o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (aw_held & w_held) begin
            w_held <= 1'b0;
        end else if (i_wvalid & o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= PFM_RESP_OK;
        end else if (aw_held & w_held) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (aw_addr == PFM_OFS_CTRL || aw_addr == PFM_OFS_STATUS) ? PFM_RESP_OK : PFM_RESP_ERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // firmware configuration
    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            ctrl <= PFM_CTRL_RST;
        end else if (aw_held & w_held & (aw_addr == PFM_OFS_CTRL)) begin
            if (w_strb[0]) begin
                ctrl[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                ctrl[PFM_C_BITS-1:8] <= w_data[PFM_C_BITS-1:8];
            end
        end
    end

    // axi4-lite read path
    assign status_word = {25'h0, dbuf_en, i_scan_pin_select, rom32, boot_width, vl_act, gfx_act};
    assign o_arready   = ~o_rvalid;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rvalid <= 1'b0;
        end else if (i_arvalid & o_arready) begin
            o_rvalid <= 1'b1;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= PFM_RESP_OK;
        end else if (i_arvalid & o_arready) begin
            case (i_araddr)
                PFM_OFS_CTRL: begin
                    o_rdata <= {{(32-PFM_C_BITS){1'b0}}, ctrl};
                    o_rresp <= PFM_RESP_OK;
                end
                PFM_OFS_STATUS: begin
                    o_rdata <= status_word;
                    o_rresp <= PFM_RESP_OK;
                end
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= PFM_RESP_ERR;
                end
            endcase
        end
    end

    // graphics / local bus exclusion
    assign gfx_avail = ~(ctrl[PFM_C_DRAM32] | rom32 | ctrl[PFM_C_VLBUS]);
    assign gfx_act   = ctrl[PFM_C_GFX] & gfx_avail;
    assign vl_act    = ctrl[PFM_C_VLBUS] & ~gfx_act;

    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            o_gfx_active <= 1'b0;
        end else begin
            o_gfx_active <= gfx_act;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            o_vl_active <= 1'b0;
        end else begin
            o_vl_active <= vl_act;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            o_boot_width <= PFM_W8;
        end else begin
            o_boot_width <= boot_width;
        end
    end

    // keyboard row alternate selection
    always_comb begin
        row_alt = 15'h0000;
        if (ctrl[PFM_C_BANKS]) begin
            row_alt = row_alt | PFM_ROW_BANKS;
        end
        if (ctrl[PFM_C_ISA]) begin
            row_alt = row_alt | PFM_ROW_ISA;
        end
        row_alt[PFM_ROW_TOP_MEMORY_ADDRESS_BIT] = ctrl[PFM_C_TOP_MEMORY_ADDRESS_BIT];
        row_alt[PFM_ROW_R32]  = rom32;
    end

    genvar gi;
    generate
        for (gi = 0; gi < PFM_CTLPINS; gi++) begin : g_ctl
            always_ff @(posedge i_mclk) begin
                if (any_reset) begin
                    o_ctl_pad[gi] <= PAD_OFF;
                end else begin
                    o_ctl_pad[gi] <= gfx_act ? i_gfx_drv[gi] : (vl_act ? i_vl_drv[gi] : PAD_OFF);
                end
            end
        end
        for (gi = 0; gi < PFM_KROWS; gi++) begin : g_row
            pfm_pad_t alt_drv;
            assign alt_drv = (gi == PFM_ROW_TOP_MEMORY_ADDRESS_BIT) ? pfm_pad_t'{out: i_mem_ma[12], oe_n: 1'b0} : i_kalt_drv[gi];
            always_ff @(posedge i_mclk) begin
                if (any_reset) begin
                    o_kbd_pad[gi] <= PAD_OFF;
                end else begin
                    o_kbd_pad[gi] <= pad_pick(row_alt[gi], alt_drv, i_kbd_drv[gi]);
                end
            end
        end
        for (gi = 0; gi < PFM_MAPINS; gi++) begin : g_ma
            always_ff @(posedge i_mclk) begin
                if (any_reset && gi < 2) begin
                    o_ma_pad[gi] <= PAD_OFF;
                end else begin
                    o_ma_pad[gi] <= '{out: i_mem_ma[gi], oe_n: 1'b0};
                end
            end
        end
        for (gi = 0; gi < PFM_GCS; gi++) begin : g_gcs
            logic dbuf_here;
            logic rom3_here;
            assign dbuf_here = dbuf_en & PFM_GCS_DBUF[gi];
            assign rom3_here = ctrl[PFM_C_ROM3] & (rom3_tgt == 4'(gi)) & ~dbuf_here;
            always_ff @(posedge i_mclk) begin
                if (any_reset) begin
                    o_gcs_pad[gi] <= PAD_OFF;
                end else if (dbuf_here) begin
                    o_gcs_pad[gi] <= i_dbuf_drv[gi];
                end else if (rom3_here) begin
                    o_gcs_pad[gi] <= '{out: i_third_rom_select, oe_n: 1'b0};
                end else begin
                    o_gcs_pad[gi] <= i_gpio_drv[gi];
                end
            end
        end
        for (gi = 0; gi < PFM_PBPINS; gi++) begin : g_pb
            always_ff @(posedge i_mclk) begin
                if (any_reset) begin
                    o_pb_pad[gi] <= PAD_OFF;
                end else begin
                    o_pb_pad[gi] <= pad_pick(ctrl[PFM_C_PAR], i_par_drv[gi], i_sockb_drv[gi]);
                end
            end
        end
        for (gi = 0; gi < PFM_SCAN; gi++) begin : g_scan
            always_ff @(posedge i_mclk) begin
                if (i_srst) begin
                    o_scan_pad[gi] <= PAD_OFF;
                end else begin
                    o_scan_pad[gi] <= pad_pick(i_scan_pin_select, i_scan_drv[gi], i_card_drv[gi]);
                end
            end
        end
    endgenerate

    // single uart routed to serial or infrared
    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            o_ser_txd <= 1'b1;
        end else begin
            o_ser_txd <= ctrl[PFM_C_IR] ? 1'b1 : i_uart_txd;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            o_ir_txd <= 1'b1;
        end else begin
            o_ir_txd <= ctrl[PFM_C_IR] ? i_uart_txd : 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (any_reset) begin
            o_uart_rxd <= 1'b1;
        end else begin
            o_uart_rxd <= ctrl[PFM_C_IR] ? i_ir_rxd : i_ser_rxd;
        end
    end
endmodule : pfm_pin_mux

// file: tb/pfm_pin_mux_props.sv
// assertion checker for the pin function mux
`timescale 1ns/1ps
module pfm_pin_mux_props (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_hw_reset,
    input wire logic i_scan_pin_select,
    input pfm_pkg::pfm_pad_t [pfm_pkg::PFM_CTLPINS-1:0] i_gfx_drv,
    input pfm_pkg::pfm_pad_t [pfm_pkg::PFM_CTLPINS-1:0] i_vl_drv,
    input pfm_pkg::pfm_pad_t [pfm_pkg::PFM_CTLPINS-1:0] o_ctl_pad,
    input pfm_pkg::pfm_pad_t [pfm_pkg::PFM_SCAN-1:0] i_scan_drv,
    input pfm_pkg::pfm_pad_t [pfm_pkg::PFM_SCAN-1:0] o_scan_pad,
    input pfm_pkg::pfm_pad_t [pfm_pkg::PFM_MAPINS-1:0] o_ma_pad,
    input wire logic o_ser_txd,
    input wire logic o_ir_txd,
    input wire logic o_gfx_active,
    input wire logic o_vl_active,
    input wire logic [1:0] o_boot_width
);
    import pfm_pkg::*;
    logic [1:0] settled;
    // cycles since the last reset of either kind
    always_ff @(posedge i_mclk) begin
        if (i_srst || i_hw_reset) begin
            settled <= 2'h0;
        end else if (settled != 2'h3) begin
            settled <= settled + 2'h1;
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    sequence s_vl_on;
        o_vl_active ##1 o_vl_active;
    endsequence
    sequence s_gfx_on;
        o_gfx_active ##1 o_gfx_active;
    endsequence
    a_vl_ctl_pads: assert property (s_vl_on |-> o_ctl_pad == $past(i_vl_drv))
        else $error("control pads not from local bus");
    a_gfx_ctl_pads: assert property (s_gfx_on |-> o_ctl_pad == $past(i_gfx_drv))
        else $error("control pads not from graphics");
    a_gfx_vl_excl: assert property (!(o_gfx_active && o_vl_active))
        else $error("graphics and local bus both active");
    a_rom32_no_gfx: assert property (o_boot_width == PFM_W32 |-> !o_gfx_active)
        else $error("graphics active with wide rom");
    a_one_uart_port: assert property (o_ser_txd || o_ir_txd)
        else $error("both uart ports driven");
    a_boot_hold: assert property (settled == 2'h3 |-> $stable(o_boot_width))
        else $error("boot width changed");
    a_scan_route: assert property (settled == 2'h3 && i_scan_pin_select && $past(i_scan_pin_select) |-> o_scan_pad == $past(i_scan_drv))
        else $error("scan pads not from scan logic");
    a_hw_ma_rel: assert property (i_hw_reset && $past(i_hw_reset) |-> o_ma_pad[0].oe_n && o_ma_pad[1].oe_n)
        else $error("strap pads driven in reset");
endmodule : pfm_pin_mux_props

// file: tb/pfm_board.sv
// board model: strap resistors and a loopback serial cable
`timescale 1ns/1ps
module pfm_board (
    input wire logic [1:0] i_width_sel,
    input wire logic i_dbuf_sel,
    input pfm_pkg::pfm_pad_t [1:0] i_ma_low_pad,
    input wire logic i_ser_txd,
    input wire logic i_ir_txd,
    output logic [1:0] o_ma_level,
    output logic o_dbuf_level,
    output logic o_ser_rxd,
    output logic o_ir_rxd
);
    import pfm_pkg::*;
    // straps pull released pins, a driven pin wins
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            o_ma_level[i] = i_ma_low_pad[i].oe_n ? i_width_sel[i] : i_ma_low_pad[i].out;
        end
    end
    assign o_dbuf_level = i_dbuf_sel;
    assign o_ser_rxd = i_ser_txd;
    assign o_ir_rxd = i_ir_txd;
endmodule : pfm_board

// file: tb/pfm_pin_mux_tb.sv
// self-checking bench for the pin function mux
`timescale 1ns/1ps
module pfm_pin_mux_tb;
    import pfm_pkg::*;
    logic i_mclk, i_srst, i_hw_reset, i_scan_pin_select, i_dbuf_strap, i_third_rom_select, dbuf_sel;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rdat;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, i_ma_pad_in, o_boot_width, width_sel, resp, e;
    logic [12:0] i_mem_ma;
    logic i_uart_txd, i_ser_rxd, i_ir_rxd, o_ser_txd, o_ir_txd, o_uart_rxd, o_gfx_active, o_vl_active;
    pfm_pad_t [PFM_CTLPINS-1:0] i_gfx_drv, i_vl_drv, o_ctl_pad;
    pfm_pad_t [PFM_KROWS-1:0] i_kbd_drv, i_kalt_drv, o_kbd_pad;
    pfm_pad_t [PFM_MAPINS-1:0] o_ma_pad;
    pfm_pad_t [PFM_GCS-1:0] i_gpio_drv, i_dbuf_drv, o_gcs_pad;
    pfm_pad_t [PFM_PBPINS-1:0] i_par_drv, i_sockb_drv, o_pb_pad;
    pfm_pad_t [PFM_SCAN-1:0] i_card_drv, i_scan_drv, o_scan_pad;
    int failures, comparisons;
    pfm_pin_mux pfm_pin_mux_inst (.i_mclk, .i_srst, .i_hw_reset, .i_scan_pin_select, .i_dbuf_strap, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_gfx_drv, .i_vl_drv,
        .i_kbd_drv, .i_kalt_drv, .i_mem_ma, .i_gpio_drv, .i_dbuf_drv, .i_third_rom_select, .i_par_drv,
        .i_sockb_drv, .i_card_drv, .i_scan_drv, .i_uart_txd, .i_ser_rxd, .i_ir_rxd, .i_ma_pad_in, .o_ctl_pad,
        .o_kbd_pad, .o_ma_pad, .o_gcs_pad, .o_pb_pad, .o_scan_pad, .o_ser_txd, .o_ir_txd, .o_uart_rxd,
        .o_gfx_active, .o_vl_active, .o_boot_width);
    pfm_board pfm_board_inst (.i_width_sel(width_sel), .i_dbuf_sel(dbuf_sel), .i_ma_low_pad(o_ma_pad[1:0]),
        .i_ser_txd(o_ser_txd), .i_ir_txd(o_ir_txd), .o_ma_level(i_ma_pad_in), .o_dbuf_level(i_dbuf_strap),
        .o_ser_rxd(i_ser_rxd), .o_ir_rxd(i_ir_rxd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
        resp = o_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        i_rready <= 1'b0;
        resp = o_rresp;
        rdat = o_rdata;
    endtask : rd
    task automatic t_boot(input logic [1:0] ws, input logic db, input logic [1:0] ew);
        @(posedge i_mclk);
        width_sel <= ws;
        dbuf_sel <= db;
        i_srst <= 1'b1;
        repeat (10) @(posedge i_mclk);
        i_srst <= 1'b0;
        width_sel <= ~ws;
        settle;
        chk(32'(o_boot_width), 32'(ew));
        rd(PFM_OFS_STATUS);
        chk(32'(rdat[6:2]), 32'({db, 1'b0, ew == PFM_W32, ew}));
        wr(PFM_OFS_CTRL, 32'h1);
        settle;
        chk(32'(o_gfx_active), 32'(ew != PFM_W32));
        chk(32'(o_kbd_pad[PFM_ROW_R32]), (ew == PFM_W32) ? 32'h2 : 32'h1);
    endtask : t_boot
    task automatic t_ctrl(input logic [31:0] c, input logic eg, input logic ev);
        wr(PFM_OFS_CTRL, c);
        settle;
        chk(32'({o_gfx_active, o_vl_active}), 32'({eg, ev}));
        if (eg || ev) chk(32'(o_ctl_pad), 32'(ev ? i_vl_drv : i_gfx_drv));
        else chk(32'(o_ctl_pad), 32'({PFM_CTLPINS{2'h1}}));
    endtask : t_ctrl
    task automatic t_rows;
        wr(PFM_OFS_CTRL, 32'hE0);
        settle;
        for (int r = 0; r < PFM_KROWS; r++) begin
            e = (PFM_ROW_BANKS[r] || PFM_ROW_ISA[r]) ? 2'h2 : (r == PFM_ROW_TOP_MEMORY_ADDRESS_BIT) ? 2'h0 : 2'h1;
            chk(32'(o_kbd_pad[r]), 32'(e));
        end
    endtask : t_rows
    task automatic t_sel;
        for (int s = 0; s < 2; s++) begin
            wr(PFM_OFS_CTRL, (32'(s) << PFM_C_IR) | (32'(s) << PFM_C_PAR));
            @(posedge i_mclk);
            i_uart_txd <= 1'b0;
            i_scan_pin_select <= s[0];
            settle;
            chk(32'({o_ir_txd, o_ser_txd, o_uart_rxd}), s ? 32'h2 : 32'h4);
            chk(32'(o_pb_pad), 32'(s ? i_par_drv : i_sockb_drv));
            chk(32'(o_scan_pad), 32'(s ? i_scan_drv : i_card_drv));
            @(posedge i_mclk);
            i_uart_txd <= 1'b1;
        end
    endtask : t_sel
    task automatic t_rom3;
        logic [3:0] tg [3] = '{4'h3, 4'hE, 4'hF};
        foreach (tg[k]) begin
            wr(PFM_OFS_CTRL, 32'h100 | (32'(tg[k]) << PFM_C_TGT_LO));
            settle;
            for (int p = 0; p < PFM_GCS; p++) begin
                e = PFM_GCS_DBUF[p] ? 2'h0 : (p == tg[k]) ? 2'h2 : 2'h1;
                chk(32'(o_gcs_pad[p]), 32'(e));
            end
        end
    endtask : t_rom3
    task automatic t_err;
        wr(8'h08, 32'h1);
        chk(32'(resp), 32'(PFM_RESP_ERR));
        rd(8'h08);
        chk({rdat[29:0], resp}, 32'(PFM_RESP_ERR));
        wr(PFM_OFS_STATUS, 32'hFF);
        chk(32'(resp), 32'(PFM_RESP_OK));
        rd(PFM_OFS_CTRL);
        chk(rdat, 32'h1F00);
    endtask : t_err
    task automatic t_hwrst;
        wr(PFM_OFS_CTRL, 32'h1);
        @(posedge i_mclk);
        i_hw_reset <= 1'b1;
        settle;
        chk(32'({o_ma_pad[1].oe_n, o_ma_pad[0].oe_n, o_gfx_active}), 32'h6);
        @(posedge i_mclk);
        i_hw_reset <= 1'b0;
        settle;
        rd(PFM_OFS_CTRL);
        chk({rdat[29:0], o_boot_width}, 32'(PFM_W16));
    endtask : t_hwrst
    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        failures++;
        end_of_test;
    end
    initial begin
        {i_srst, i_hw_reset, i_scan_pin_select, dbuf_sel, width_sel} = 6'h20;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = '0;
        {i_wstrb, i_third_rom_select, i_uart_txd, i_mem_ma} = 19'h7E000;
        i_gfx_drv = {PFM_CTLPINS{2'h2}};
        i_vl_drv = {PFM_CTLPINS{2'h0}};
        i_kbd_drv = {PFM_KROWS{2'h1}};
        i_kalt_drv = {PFM_KROWS{2'h2}};
        i_gpio_drv = {PFM_GCS{2'h1}};
        i_dbuf_drv = {PFM_GCS{2'h0}};
        {i_par_drv, i_sockb_drv} = {{PFM_PBPINS{2'h2}}, {PFM_PBPINS{2'h0}}};
        {i_scan_drv, i_card_drv} = {{PFM_SCAN{2'h2}}, {PFM_SCAN{2'h0}}};
        t_boot(2'h0, 1'b0, PFM_W8);
        t_boot(2'h3, 1'b0, PFM_W32);
        t_boot(2'h2, 1'b0, PFM_W32);
        t_boot(2'h1, 1'b1, PFM_W16);
        t_ctrl(32'h5, 1'b0, 1'b1);
        t_ctrl(32'h1, 1'b1, 1'b0);
        t_ctrl(32'h6, 1'b0, 1'b1);
        t_ctrl(32'h3, 1'b0, 1'b0);
        t_rows;
        t_sel;
        t_rom3;
        t_err;
        t_hwrst;
        end_of_test;
    end
endmodule : pfm_pin_mux_tb
bind pfm_pin_mux pfm_pin_mux_props pfm_pin_mux_props_inst (.i_mclk, .i_srst, .i_hw_reset, .i_scan_pin_select,
    .i_gfx_drv, .i_vl_drv, .o_ctl_pad, .i_scan_drv, .o_scan_pad, .o_ma_pad, .o_ser_txd, .o_ir_txd,
    .o_gfx_active, .o_vl_active, .o_boot_width);
